// ==== design/ief_pkg.sv ====
// Constants, types and register map of the transient earth fault trip logic
package ief_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_MS = 10;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned FORCE_TIMEOUT_S = 300;
   localparam logic [15:0] FORCE_TICKS = 16'(FORCE_TIMEOUT_S * 1000 / TICK_MS);
   localparam int unsigned PEAK_SPACING_MS = 10;
   localparam logic [15:0] PEAK_SPACING_TICKS = 16'(PEAK_SPACING_MS / TICK_MS);
   localparam logic [15:0] SET_MAX = 16'h7530;
   localparam logic [15:0] OP_MIN = 16'h0002;
   localparam logic [15:0] RST_MIN = 16'h0006;
   localparam logic [15:0] INT_MIN = 16'h0001;
   localparam logic [4:0] PEAK_MIN = 5'h01;
   localparam logic [4:0] PEAK_MAX = 5'h14;
   localparam logic [15:0] OP_RST = 16'h0010;
   localparam logic [4:0] PEAK_RST = 5'h02;
   localparam logic [15:0] RSTDLY_RST = 16'h0006;
   localparam logic [15:0] INT_RST = 16'h0014;
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_START_CNT = 8'h08;
   localparam logic [7:0] ADDR_TRIP_CNT = 8'h0C;
   localparam logic [7:0] ADDR_REC_SEL = 8'h20;
   localparam logic [7:0] ADDR_REC_STAMP = 8'h24;
   localparam logic [7:0] ADDR_REC_MEAS = 8'h28;
   localparam logic [7:0] ADDR_REC_INFO = 8'h2C;
   localparam logic [1:0] ADDR_GRP_BLK = 2'h1;
   localparam int CTRL_FORCE = 0;
   localparam int CTRL_DIR = 1;
   localparam int CTRL_CLR_START = 2;
   localparam int CTRL_CLR_TRIP = 3;
   localparam int CTRL_GRP_LO = 4;
   localparam int CTRL_SRC_LO = 6;
   localparam int STAT_BLOCKED = 0;
   localparam int STAT_START = 1;
   localparam int STAT_TRIP = 2;
   localparam int STAT_GRP_LO = 3;
   localparam int STAT_REJECT = 5;
   localparam logic [2:0] SRC_MANUAL = 3'h0;
   localparam logic [2:0] SRC_DIGITAL = 3'h1;
   localparam logic [2:0] SRC_VIRTUAL_IN = 3'h2;
   localparam logic [2:0] SRC_INDICATOR = 3'h3;
   localparam logic [2:0] SRC_VIRTUAL_OUT = 3'h4;
   typedef struct packed {
      logic valid;
      logic reverse;
      logic above_fund;
      logic [15:0] amp;
   } ief_peak_s;
   typedef struct packed {
      logic [31:0] stamp;
      logic [15:0] volt;
      logic [15:0] cur;
      logic [6:0] pct;
      logic [1:0] grp;
      logic [7:0] rev;
      logic [7:0] fwd;
   } ief_rec_s;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIP} ief_state_e;
endpackage : ief_pkg

// ==== design/ief_trip_logic.sv ====
// Intermittent transient earth fault trip decision logic with AHB-Lite register slave
`timescale 1ns/1ps
module ief_trip_logic #(
   parameter int unsigned TICK_CYCLES = ief_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire ief_pkg::ief_peak_s peak_in,
   input wire logic [15:0] residual_voltage,
   input wire logic [31:0] time_stamp,
   input wire logic block_in,
   input wire logic [1:0] di_group,
   input wire logic [1:0] vi_group,
   input wire logic [1:0] led_group,
   input wire logic [1:0] vo_group,
   output logic start_out,
   output logic trip_out,
   output logic blocked_out,
   output logic force_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   ief_pkg::ief_state_e state_reg;
   logic [31:0] tick_cnt_reg;
   logic tick;
   logic [15:0] op_dly_reg [4];
   logic [4:0] peaks_reg [4];
   logic [15:0] rst_dly_reg [4];
   logic [15:0] int_reg [4];
   ief_pkg::ief_rec_s rec_reg [8];
   logic [2:0] rec_ptr_reg;
   logic [2:0] rec_sel_reg;
   logic force_reg;
   logic [15:0] force_cnt_reg;
   logic frc_start_reg;
   logic frc_trip_reg;
   logic dir_reg;
   logic [1:0] man_grp_reg;
   logic [2:0] src_reg;
   logic reject_reg;
   logic [31:0] start_cnt_reg;
   logic [31:0] trip_cnt_reg;
   logic [15:0] op_acc_reg;
   logic [15:0] int_cnt_reg;
   logic [15:0] rst_cnt_reg;
   logic [7:0] peak_cnt_reg;
   logic [7:0] fwd_reg;
   logic [7:0] rev_reg;
   logic [15:0] max_cur_reg;
   logic [15:0] max_volt_reg;
   logic perm_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [1:0] grp;
   logic match;
   logic op_done;
   logic trip_cond;
   logic int_expire;
   logic rst_expire;
   logic release_ev;
   logic start_ev;
   logic trip_ev;
   logic [6:0] pct_calc;
   logic [22:0] pct_prod;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_grp;
   logic [1:0] wg;
   logic [1:0] wk;
   logic set_ok;
   logic [15:0] wv;
   logic [2:0] rec_idx;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [1:0] pick_group(input logic [2:0] src, input logic [1:0] man,
                                             input logic [1:0] di, input logic [1:0] vi,
                                             input logic [1:0] led, input logic [1:0] vo);
      case (src)
         ief_pkg::SRC_DIGITAL: pick_group = di;
         ief_pkg::SRC_VIRTUAL_IN: pick_group = vi;
         ief_pkg::SRC_INDICATOR: pick_group = led;
         ief_pkg::SRC_VIRTUAL_OUT: pick_group = vo;
         default: pick_group = man;
      endcase
   endfunction : pick_group

   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo);
      in_range = (v >= lo) && (v <= ief_pkg::SET_MAX);
   endfunction : in_range

   ////////////////////////////////////////////////////////////////////////////
   // Time base
   assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || tick)
         tick_cnt_reg <= 32'h0000_0000;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decision terms
   assign grp = pick_group(src_reg, man_grp_reg, di_group, vi_group, led_group, vo_group);
   assign match = peak_in.valid && (peak_in.reverse == dir_reg);
   assign op_done = (op_acc_reg >= op_dly_reg[grp]);
   assign trip_cond = (state_reg == ief_pkg::ST_RUN) && op_done && perm_reg
                      && (peak_cnt_reg >= {3'h0, peaks_reg[grp]});
   assign int_expire = (state_reg == ief_pkg::ST_RUN) && tick && !match
                       && (int_cnt_reg + 16'h0001 >= int_reg[grp]);
   assign rst_expire = (state_reg == ief_pkg::ST_TRIP) && (rst_cnt_reg >= rst_dly_reg[grp]);
   assign release_ev = (!trip_cond && (int_expire || ((state_reg == ief_pkg::ST_RUN) && block_in)))
                       || rst_expire;
   assign start_ev = (state_reg == ief_pkg::ST_IDLE) && !block_in && match;
   assign trip_ev = trip_cond && !block_in;
   assign pct_prod = 23'(op_acc_reg) * 23'(ief_pkg::PCT_FULL);
   assign pct_calc = (state_reg == ief_pkg::ST_TRIP) ? ief_pkg::PCT_FULL
                     : (op_done ? ief_pkg::PCT_FULL - 7'h01 : 7'(pct_prod / 23'(op_dly_reg[grp])));

   ////////////////////////////////////////////////////////////////////////////
   // Stage state machine and timers
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         state_reg <= ief_pkg::ST_IDLE;
      else
      begin
         case (state_reg)
            ief_pkg::ST_IDLE: if (start_ev) state_reg <= ief_pkg::ST_RUN;
            ief_pkg::ST_RUN:
               if (trip_ev)
                  state_reg <= ief_pkg::ST_TRIP;
               else if (release_ev)
                  state_reg <= ief_pkg::ST_IDLE;
            ief_pkg::ST_TRIP: if (rst_expire) state_reg <= ief_pkg::ST_IDLE;
            default: state_reg <= ief_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || release_ev || state_reg == ief_pkg::ST_IDLE)
      begin
         op_acc_reg <= 16'h0000;
         int_cnt_reg <= 16'h0000;
         peak_cnt_reg <= start_ev ? 8'h01 : 8'h00;
         perm_reg <= start_ev && peak_in.above_fund;
      end
      else
      begin
         if (tick && !op_done)
            op_acc_reg <= op_acc_reg + 16'h0001;
         if (match)
            int_cnt_reg <= 16'h0000;
         else if (tick)
            int_cnt_reg <= int_cnt_reg + 16'h0001;
         if (match && peak_cnt_reg != 8'hFF)
            peak_cnt_reg <= peak_cnt_reg + 8'h01;
         if (match && peak_in.above_fund)
            perm_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || state_reg != ief_pkg::ST_TRIP)
         rst_cnt_reg <= 16'h0000;
      else if (tick && !rst_expire)
         rst_cnt_reg <= rst_cnt_reg + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault tallies and record store
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || (state_reg == ief_pkg::ST_IDLE && !start_ev))
      begin
         fwd_reg <= 8'h00;
         rev_reg <= 8'h00;
         max_cur_reg <= 16'h0000;
         max_volt_reg <= 16'h0000;
      end
      else
      begin
         if (peak_in.valid && !peak_in.reverse && fwd_reg != 8'hFF)
            fwd_reg <= fwd_reg + 8'h01;
         if (peak_in.valid && peak_in.reverse && rev_reg != 8'hFF)
            rev_reg <= rev_reg + 8'h01;
         if (peak_in.valid && peak_in.amp > max_cur_reg)
            max_cur_reg <= peak_in.amp;
         if (residual_voltage > max_volt_reg)
            max_volt_reg <= residual_voltage;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         rec_ptr_reg <= 3'h0;
      else if (release_ev)
      begin
         rec_reg[rec_ptr_reg] <= '{stamp: time_stamp, volt: max_volt_reg, cur: max_cur_reg, pct: pct_calc,
                                   grp: grp, rev: rev_reg, fwd: fwd_reg};
         rec_ptr_reg <= rec_ptr_reg + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event counters
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         start_cnt_reg <= 32'h0000_0000;
         trip_cnt_reg <= 32'h0000_0000;
      end
      else
      begin
         if (start_ev)
            start_cnt_reg <= (wr_ctrl && hwdata[ief_pkg::CTRL_CLR_START]) ? 32'h0000_0001
                             : start_cnt_reg + 32'h0000_0001;
         else if (wr_ctrl && hwdata[ief_pkg::CTRL_CLR_START])
            start_cnt_reg <= 32'h0000_0000;
         if (trip_ev && state_reg == ief_pkg::ST_RUN)
            trip_cnt_reg <= (wr_ctrl && hwdata[ief_pkg::CTRL_CLR_TRIP]) ? 32'h0000_0001
                            : trip_cnt_reg + 32'h0000_0001;
         else if (wr_ctrl && hwdata[ief_pkg::CTRL_CLR_TRIP])
            trip_cnt_reg <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   assign wr_ctrl = wr_pend_reg && (wr_addr_reg == ief_pkg::ADDR_CTRL);
   assign wr_stat = wr_pend_reg && (wr_addr_reg == ief_pkg::ADDR_STATUS);
   assign wr_grp = wr_pend_reg && (wr_addr_reg[7:6] == ief_pkg::ADDR_GRP_BLK);
   assign wg = wr_addr_reg[5:4];
   assign wk = wr_addr_reg[3:2];
   assign wv = hwdata[15:0];

   always_comb
   begin
      case (wk)
         2'h0: set_ok = in_range(wv, ief_pkg::OP_MIN)
                        && ({5'h00, wv} >= 21'(peaks_reg[wg]) * 21'(ief_pkg::PEAK_SPACING_TICKS));
         2'h1: set_ok = (wv >= 16'(ief_pkg::PEAK_MIN)) && (wv <= 16'(ief_pkg::PEAK_MAX))
                        && (21'(wv) * 21'(ief_pkg::PEAK_SPACING_TICKS) <= {5'h00, op_dly_reg[wg]});
         2'h2: set_ok = in_range(wv, ief_pkg::RST_MIN);
         default: set_ok = in_range(wv, ief_pkg::INT_MIN);
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         for (int g = 0; g < 4; g++)
         begin
            op_dly_reg[g] <= ief_pkg::OP_RST;
            peaks_reg[g] <= ief_pkg::PEAK_RST;
            rst_dly_reg[g] <= ief_pkg::RSTDLY_RST;
            int_reg[g] <= ief_pkg::INT_RST;
         end
      end
      else if (wr_grp && set_ok)
      begin
         case (wk)
            2'h0: op_dly_reg[wg] <= wv;
            2'h1: peaks_reg[wg] <= wv[4:0];
            2'h2: rst_dly_reg[wg] <= wv;
            default: int_reg[wg] <= wv;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         reject_reg <= 1'b0;
      else if (wr_grp && !set_ok)
         reject_reg <= 1'b1;
      else if (wr_stat && hwdata[ief_pkg::STAT_REJECT])
         reject_reg <= 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         dir_reg <= 1'b0;
         man_grp_reg <= 2'h0;
         src_reg <= ief_pkg::SRC_MANUAL;
         rec_sel_reg <= 3'h0;
      end
      else if (wr_ctrl)
      begin
         dir_reg <= hwdata[ief_pkg::CTRL_DIR];
         man_grp_reg <= hwdata[ief_pkg::CTRL_GRP_LO +: 2];
         src_reg <= hwdata[ief_pkg::CTRL_SRC_LO +: 3];
      end
      else if (wr_pend_reg && wr_addr_reg == ief_pkg::ADDR_REC_SEL)
         rec_sel_reg <= hwdata[2:0];
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         force_reg <= 1'b0;
         force_cnt_reg <= 16'h0000;
      end
      else if (wr_ctrl)
      begin
         force_reg <= hwdata[ief_pkg::CTRL_FORCE];
         force_cnt_reg <= 16'h0000;
      end
      else if (force_reg && tick)
      begin
         force_cnt_reg <= force_cnt_reg + 16'h0001;
         if (force_cnt_reg + 16'h0001 >= ief_pkg::FORCE_TICKS)
            force_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || !force_reg)
      begin
         frc_start_reg <= 1'b0;
         frc_trip_reg <= 1'b0;
      end
      else if (wr_stat)
      begin
         frc_start_reg <= hwdata[ief_pkg::STAT_START];
         frc_trip_reg <= hwdata[ief_pkg::STAT_TRIP];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stage outputs
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         start_out <= 1'b0;
         trip_out <= 1'b0;
         blocked_out <= 1'b0;
         force_out <= 1'b0;
      end
      else
      begin
         start_out <= force_reg ? frc_start_reg : (state_reg != ief_pkg::ST_IDLE);
         trip_out <= force_reg ? frc_trip_reg : (state_reg == ief_pkg::ST_TRIP);
         blocked_out <= block_in;
         force_out <= force_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   assign rec_idx = rec_ptr_reg - 3'h1 - rec_sel_reg;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
         wr_addr_reg <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite)
         begin
            hrdata <= 32'h0000_0000;
            case (haddr[7:0])
               ief_pkg::ADDR_CTRL: hrdata <= {23'h00_0000, src_reg, man_grp_reg, 2'h0, dir_reg, force_reg};
               ief_pkg::ADDR_STATUS: hrdata <= {26'h000_0000, reject_reg, grp, trip_out, start_out, blocked_out};
               ief_pkg::ADDR_START_CNT: hrdata <= start_cnt_reg;
               ief_pkg::ADDR_TRIP_CNT: hrdata <= trip_cnt_reg;
               ief_pkg::ADDR_REC_SEL: hrdata <= {29'h0000_0000, rec_sel_reg};
               ief_pkg::ADDR_REC_STAMP: hrdata <= rec_reg[rec_idx].stamp;
               ief_pkg::ADDR_REC_MEAS: hrdata <= {rec_reg[rec_idx].volt, rec_reg[rec_idx].cur};
               ief_pkg::ADDR_REC_INFO: hrdata <= {7'h00, rec_reg[rec_idx].pct, rec_reg[rec_idx].grp,
                                                 rec_reg[rec_idx].rev, rec_reg[rec_idx].fwd};
               default:
                  if (haddr[7:6] == ief_pkg::ADDR_GRP_BLK)
                  begin
                     case (haddr[3:2])
                        2'h0: hrdata <= {16'h0000, op_dly_reg[haddr[5:4]]};
                        2'h1: hrdata <= {27'h000_0000, peaks_reg[haddr[5:4]]};
                        2'h2: hrdata <= {16'h0000, rst_dly_reg[haddr[5:4]]};
                        default: hrdata <= {16'h0000, int_reg[haddr[5:4]]};
                     endcase
                  end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   trip_all_criteria_a: assert property ((state_reg == ief_pkg::ST_RUN) ##1 (state_reg == ief_pkg::ST_TRIP)
      |-> $past(op_acc_reg) >= $past(op_dly_reg[grp]) && $past(perm_reg)
          && $past(peak_cnt_reg) >= {3'h0, $past(peaks_reg[grp])})
      else $error("trip without all criteria");
   peak_set_range_a: assert property (peaks_reg[grp] >= ief_pkg::PEAK_MIN && peaks_reg[grp] <= ief_pkg::PEAK_MAX)
      else $error("peak count setting out of range");
   delay_set_range_a: assert property (op_dly_reg[grp] >= ief_pkg::OP_MIN && rst_dly_reg[grp] >= ief_pkg::RST_MIN
      && int_reg[grp] >= ief_pkg::INT_MIN && int_reg[grp] <= ief_pkg::SET_MAX)
      else $error("time setting out of range");
   set_consistent_a: assert property (wr_grp && !set_ok |=> $stable(op_dly_reg[0])
      && $stable(peaks_reg[0]) && reject_reg)
      else $error("bad setting accepted");
   instant_trip_a: assert property (trip_cond && !block_in |=> state_reg == ief_pkg::ST_TRIP ##1 trip_out)
      else $error("trip not issued at once");
   window_release_a: assert property (int_expire && !trip_cond |=> state_reg == ief_pkg::ST_IDLE
      && op_acc_reg == 16'h0000 && peak_cnt_reg == 8'h00 ##1 !start_out || force_reg)
      else $error("release after window failed");
   trip_hold_a: assert property ((state_reg == ief_pkg::ST_TRIP) && (rst_cnt_reg < rst_dly_reg[grp])
      |=> state_reg == ief_pkg::ST_TRIP)
      else $error("trip dropped before reset delay");
   block_holds_a: assert property (block_in && state_reg == ief_pkg::ST_IDLE |=> state_reg == ief_pkg::ST_IDLE
      && blocked_out)
      else $error("stage started while blocked");
   force_timeout_a: assert property (force_reg && tick && !wr_ctrl && force_cnt_reg == ief_pkg::FORCE_TICKS - 16'h0001
      |=> !force_reg ##1 !force_out)
      else $error("force flag not timed out");
   count_clear_a: assert property (wr_ctrl && hwdata[ief_pkg::CTRL_CLR_START] && !start_ev
      |=> start_cnt_reg == 32'h0000_0000)
      else $error("start counter not cleared");
endmodule : ief_trip_logic

// ==== sim/ief_peak_src.sv ====
// Model of the transient peak detector feeding the trip logic
`timescale 1ns/1ps
module ief_peak_src (
   input wire logic clk_sys,
   output ief_pkg::ief_peak_s peak_in,
   output logic [15:0] residual_voltage,
   output logic [31:0] time_stamp
);
   initial peak_in = '0;
   initial residual_voltage = 16'h0100;
   initial time_stamp = 32'h0000_0000;
   always @(posedge clk_sys) time_stamp <= time_stamp + 32'h0000_0001;
   // One-cycle peak report; amplitude fixed at 0200h, voltage steps up by 0010h with every peak
   task automatic fire(input logic rev, input logic fund);
      @(posedge clk_sys);
      peak_in <= '{1'b1, rev, fund, 16'h0200};
      residual_voltage <= residual_voltage + 16'h0010;
      @(posedge clk_sys);
      peak_in <= '{1'b0, ~rev, ~fund, 16'hFFFF};
   endtask : fire
endmodule : ief_peak_src

// ==== sim/testbench.sv ====
// Self-checking bench of the trip logic over AHB-Lite
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, block_in = 0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = '0, hwdata = '0, rd;
   logic hreadyout, hresp, start_out, trip_out, blocked_out, force_out;
   logic [31:0] hrdata, time_stamp;
   logic [15:0] residual_voltage;
   ief_pkg::ief_peak_s peak_in;
   logic [1:0] di_grp = 2'h1;
   longint t_force = 0;
   localparam int TICK = 2;
   int n_fail = 0, num_checks = 0;
   always #4 clk_sys = ~clk_sys;
   ief_peak_src src (.clk_sys(clk_sys), .peak_in(peak_in), .residual_voltage(residual_voltage),
      .time_stamp(time_stamp));
   ief_trip_logic #(.TICK_CYCLES(TICK)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .peak_in(peak_in),
      .residual_voltage(residual_voltage), .time_stamp(time_stamp), .block_in(block_in),
      .di_group(di_grp), .vi_group(2'h2), .led_group(2'h3), .vo_group(2'h0), .start_out(start_out),
      .trip_out(trip_out), .blocked_out(blocked_out), .force_out(force_out));
   ////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0000_00, a};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_out(input logic trip, input logic v);
      for (int i = 0; i < 600 && (trip ? trip_out : start_out) !== v; i++) @(posedge clk_sys);
   endtask : wait_out
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      xfer(0, 8'h40, 0); chk(rd, 32'(ief_pkg::OP_RST));
      chk(hresp, 1'b0);
      xfer(0, 8'h44, 0); chk(rd, 32'(ief_pkg::PEAK_RST));
      xfer(0, 8'h48, 0); chk(rd, 32'(ief_pkg::RSTDLY_RST));
      xfer(0, 8'h4C, 0); chk(rd, 32'(ief_pkg::INT_RST));
      xfer(0, 8'h10, 0); chk(rd, 32'h0000_0000);
      $display("test reset values done");
      xfer(1, 8'h40, 32'h0000_0004);
      src.fire(1'b0, 1'b1);
      src.fire(1'b1, 1'b1);
      repeat (3) @(posedge clk_sys);
      src.fire(1'b0, 1'b1);
      wait_out(1, 1); chk(trip_out, 1);
      chk(start_out, 1);
      xfer(0, ief_pkg::ADDR_STATUS, 0); chk(rd[2:1], 2'b11);
      repeat (6) @(posedge clk_sys);
      chk(trip_out, 1);
      wait_out(1, 0); chk(trip_out, 0);
      chk(start_out, 0);
      xfer(0, ief_pkg::ADDR_REC_INFO, 0); chk(rd[24:18], ief_pkg::PCT_FULL);
      chk(rd[15:0], 16'h0102);
      $display("test trip done");
      xfer(1, 8'h40, 32'h0000_001E);
      xfer(1, 8'h4C, 32'h0000_0002);
      src.fire(1'b0, 1'b1);
      wait_out(0, 1); wait_out(0, 0); chk(trip_out, 0);
      xfer(0, ief_pkg::ADDR_START_CNT, 0); chk(rd, 32'h0000_0002);
      xfer(0, ief_pkg::ADDR_TRIP_CNT, 0); chk(rd, 32'h0000_0001);
      $display("test release done");
      xfer(1, 8'h44, 32'h0000_0015);
      xfer(0, ief_pkg::ADDR_STATUS, 0); chk(rd[5], 1);
      xfer(1, ief_pkg::ADDR_STATUS, 32'h0000_0020);
      xfer(0, ief_pkg::ADDR_STATUS, 0); chk(rd[5], 0);
      xfer(1, 8'h40, 32'h0000_0002);
      xfer(1, 8'h44, 32'h0000_0003);
      xfer(0, ief_pkg::ADDR_STATUS, 0); chk(rd[5], 1);
      $display("test reject done");
      src.fire(1'b0, 1'b0);
      src.fire(1'b0, 1'b0);
      wait_out(0, 1); wait_out(0, 0);
      xfer(0, ief_pkg::ADDR_TRIP_CNT, 0); chk(rd, 32'h0000_0001);
      $display("test fundamental guard done");
      block_in <= 1'b1;
      src.fire(1'b0, 1'b1);
      repeat (4) @(posedge clk_sys);
      chk(start_out, 0);
      chk(blocked_out, 1);
      xfer(1, ief_pkg::ADDR_CTRL, 32'h0000_000C);
      xfer(0, ief_pkg::ADDR_TRIP_CNT, 0); chk(rd, 32'h0000_0000);
      xfer(0, ief_pkg::ADDR_START_CNT, 0); chk(rd, 32'h0000_0000);
      $display("test block and clear done");
      xfer(1, ief_pkg::ADDR_CTRL, 32'h0000_0040);
      xfer(0, ief_pkg::ADDR_STATUS, 0); chk(rd[4:3], 2'h1);
      xfer(1, ief_pkg::ADDR_CTRL, 32'h0000_0041);
      t_force = $time;
      xfer(1, ief_pkg::ADDR_STATUS, 32'h0000_0002);
      repeat (2) @(posedge clk_sys);
      chk(start_out, 1);
      chk(force_out, 1);
      for (int i = 0; i < 61000 && force_out === 1'b1; i++) @(posedge clk_sys);
      chk(32'(($time - t_force) / 8 - TICK * ief_pkg::FORCE_TICKS <= 2), 1);
      chk(start_out, 0);
      $display("test group and force done");
      results();
   end
   initial
   begin
      repeat (70000) @(posedge clk_sys);
      n_fail++;
      results();
   end
endmodule : testbench
